// File: hw/ehu_pkg.sv
// ehu_pkg: constants, carriers and helpers of the event handling unit
package ehu_pkg;
   // ==========================================================
   // register map, byte addresses on the bus
   localparam int AdrW = 12;
   localparam logic [11:0] AdrSr = 12'h000;
   localparam logic [11:0] AdrBase = 12'h004;
   localparam logic [11:0] AdrDbgStat = 12'h030;
   localparam logic [11:0] AdrDbgAddr = 12'h050;
   localparam logic [11:0] AdrSp = 12'h300;
   localparam logic [11:0] AdrState = 12'h304;
   localparam logic [1:0] RespOkay = 2'h0;
   localparam logic [1:0] RespDecErr = 2'h3;

   // ==========================================================
   // status register layout
   localparam int BitGim = 16;
   localparam int BitLvm = 17;
   localparam int BitExm = 21;
   localparam int ModeLo = 22;
   localparam int BitDbm = 26;
   localparam int BitDbg = 27;
   localparam logic [31:0] SrDbgFlag = 32'h0800_0000;
   localparam logic [31:0] SrModeMask = 32'h01c0_0000;
   localparam logic [31:0] SrReset = 32'h0041_0000;
   localparam logic [31:0] BaseReset = 32'h0000_0000;
   localparam logic [31:0] SpReset = 32'h0000_0000;

   // ==========================================================
   // vectors and stack frame
   localparam logic [13:0] OffNmi = 14'h0010;
   localparam logic [13:0] OffScall = 14'h0100;
   localparam logic [31:0] WordBytes = 32'h0000_0004;
   localparam logic [3:0] CtxWords = 4'h2;
   localparam logic [3:0] IntWords = 4'h8;
   localparam logic [3:0] SrSlot = 4'h1;
   localparam logic [3:0] RegSlot0 = 4'h2;

   typedef enum logic [2:0] {
      MdApp = 3'b000, MdSup = 3'b001, MdLv0 = 3'b010, MdLv1 = 3'b011,
      MdLv2 = 3'b100, MdLv3 = 3'b101, MdExc = 3'b110, MdNmi = 3'b111
   } ehu_mode_t;

   typedef enum logic [1:0] {StIdle = 2'b00, StPush = 2'b01, StPop = 2'b10} ehu_state_t;

   typedef struct packed {
      logic vld;
      logic crit;
      logic [13:0] off;
      logic [31:0] pc;
   } ehu_exc_t;

   typedef struct packed {
      logic take;
      logic isInt;
      ehu_mode_t mode;
      logic [5:0] setm;
      logic [13:0] off;
      logic [31:0] pc;
   } ehu_pick_t;

   typedef struct packed {
      logic scall;
      logic rete;
      logic rets;
      logic retd;
      logic [31:0] retPc;
   } ehu_insn_t;

   // base and offset are or-ed: no carry ever reaches the base bits
   function automatic logic [31:0] vecAddr(input logic [31:0] base, input logic [13:0] off);
      vecAddr = base | {18'h0, off};
   endfunction

   function automatic ehu_mode_t srMode(input logic [31:0] sr);
      srMode = ehu_mode_t'(sr[ModeLo +: 3]);
   endfunction

   function automatic logic [31:0] setMode(input logic [31:0] sr, input ehu_mode_t m);
      setMode = (sr & ~SrModeMask) | (32'(m) << ModeLo);
   endfunction

   function automatic logic isIntMode(input logic [31:0] sr);
      isIntMode = srMode(sr) inside {MdLv0, MdLv1, MdLv2, MdLv3};
   endfunction
endpackage

// File: hw/ehu_event_sel.sv
// ehu_event_sel: masking and priority choice among pending events
`timescale 1ns/1ns
`default_nettype none
module ehu_event_sel (
   input wire logic [31:0] sr,
   input wire ehu_pkg::ehu_exc_t excOld,
   input wire ehu_pkg::ehu_exc_t excYoung,
   input wire logic [3:0] intReq,
   input wire logic [13:0] intOff,
   input wire logic nmi,
   input wire logic [31:0] curPc,
   output ehu_pkg::ehu_pick_t pick
);
   ehu_pkg::ehu_exc_t exc;

   always_comb begin
      // the older instruction wins even over a worse younger one
      exc = excOld.vld ? excOld : excYoung; // RULE22
      pick = '0;
      pick.pc = curPc;
      if (exc.vld && exc.crit) begin // RULE6
         pick.take = 1'b1;
         pick.mode = ehu_pkg::MdExc;
         pick.off = exc.off;
         pick.pc = exc.pc;
         pick.setm = '1;
      end else if (nmi) begin // RULE6
         pick.take = 1'b1;
         pick.mode = ehu_pkg::MdNmi;
         pick.off = ehu_pkg::OffNmi; // RULE2
         pick.setm = '1;
      end else begin
         for (int l = 3; l >= 0; l--) begin
            if (!pick.take && intReq[l] && !sr[ehu_pkg::BitGim] && !sr[ehu_pkg::BitLvm + l]) begin // RULE5
               pick.take = 1'b1;
               pick.isInt = 1'b1;
               pick.mode = ehu_pkg::ehu_mode_t'(3'(ehu_pkg::MdLv0) + 3'(l));
               pick.off = intOff; // RULE3
               for (int k = 0; k <= l; k++) begin
                  pick.setm[1 + k] = 1'b1; // RULE7
               end
            end
         end
         if (!pick.take && exc.vld && !sr[ehu_pkg::BitExm]) begin // RULE5
            pick.take = 1'b1;
            pick.mode = ehu_pkg::MdExc;
            pick.off = exc.off;
            pick.pc = exc.pc;
            pick.setm[0] = 1'b1; // RULE11
            pick.setm[5] = 1'b1; // RULE11
         end
      end
   end
endmodule // ehu_event_sel
`default_nettype wire

// File: hw/ehu_core.sv
// ehu_core: event entry, context save and restore, debug entry, bus registers
//
// Operation
// [RULE1] handler address is vector base OR offset
// [RULE2] handlers spaced four bytes, some wider
// [RULE3] autovector offset is fourteen bits wide
// [RULE4] controller arbitrates interrupts, supplies offset
// [RULE5] masked pending events are refused
// [RULE6] critical events ignore every mask bit
// [RULE7] acceptance masks equal and lower priorities
// [RULE8] sources hold requests until accepted
// [RULE9] events push status and pc atomically
// [RULE10] interrupt levels also push six registers
// [RULE11] exceptions set exception and global masks
// [RULE12] then set mode, bank, handler pc
// [RULE13] event return pops status, pc, registers
// [RULE14] supervisor call saves, its return restores
// [RULE15] debug request enters unless debug-masked
// [RULE16] debug entry sets flag, jumps handler
// [RULE17] debug saves into dedicated return registers
// [RULE18] debug mode lets software change mode
// [RULE19] debug return restores dedicated registers
// [RULE20] higher class preempts lower ongoing handling
// [RULE21] stack traffic always uses system stack pointer
// [RULE22] oldest instruction's events are handled first
// [RULE23] restored status reapplies old masks immediately
`timescale 1ns/1ns
`default_nettype none
module ehu_core (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire ehu_pkg::ehu_exc_t excOld,
   input wire ehu_pkg::ehu_exc_t excYoung,
   input wire logic [3:0] intReq,
   input wire logic [13:0] intOff,
   input wire logic nmi,
   input wire logic dbgReq,
   input wire logic [31:0] dbgHandler,
   input wire ehu_pkg::ehu_insn_t insn,
   input wire logic [31:0] curPc,
   input wire logic [5:0][31:0] saveRegs,
   output logic busy,
   output logic evtTaken,
   output logic pcLoad,
   output logic [31:0] pcNew,
   output logic [31:0] srOut,
   output ehu_pkg::ehu_mode_t bankSel,
   output logic restWe,
   output logic [2:0] restIdx,
   output logic [31:0] restData,
   output logic stkReq,
   output logic stkWe,
   output logic [31:0] stkAddr,
   output logic [31:0] stkWdata,
   input wire logic stkAck,
   input wire logic [31:0] stkRdata
);
   // ==========================================================
   // state
   ehu_pkg::ehu_pick_t pick;
   ehu_pkg::ehu_state_t st_q;
   logic [31:0] sr_q, base_q, sp_q, dbgStat_q, dbgAddr_q;
   logic [31:0] snapSr_q, snapPc_q, newSr_q, tgt_q, popSr_q;
   logic [5:0][31:0] regs_q;
   logic [3:0] cnt_q, nWords_q, popSlot;
   logic [11:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awHas_q, wHas_q, bvalid_q, rvalid_q, pcLoad_q, evtTaken_q, restWe_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, pcNew_q, restData_q, stkAddr_q, stkWdata_q;
   logic [2:0] restIdx_q;
   logic idle, insnOk, dbgGo, evtGo, scallGo, reteGo, retsGo, retdGo, last;
   logic pushEnd, popEnd, wrDo, wrSr, wrBase, wrSp;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         wmerge[8*b +: 8] = s[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction

   // push order: pc, status, then the six banked registers
   function automatic logic [31:0] wordAt(input logic [3:0] idx);
      if (idx == ehu_pkg::SrSlot) wordAt = snapSr_q;
      else if (idx >= ehu_pkg::RegSlot0) wordAt = regs_q[3'(idx - ehu_pkg::RegSlot0)];
      else wordAt = snapPc_q;
   endfunction

   ehu_event_sel u_sel (
      .sr(sr_q),
      .excOld(excOld),
      .excYoung(excYoung),
      .intReq(intReq), // RULE4
      .intOff(intOff),
      .nmi(nmi),
      .curPc(curPc),
      .pick(pick)
   );

   // ==========================================================
   // acceptance
   assign idle = st_q == ehu_pkg::StIdle;
   assign dbgGo = idle && dbgReq && !sr_q[ehu_pkg::BitDbm] && !sr_q[ehu_pkg::BitDbg]; // RULE15
   // a pending event wins over the instruction at hand
   assign evtGo = idle && !dbgGo && pick.take; // RULE20
   assign insnOk = idle && !dbgGo && !pick.take;
   assign scallGo = insnOk && insn.scall;
   assign reteGo = insnOk && insn.rete;
   assign retsGo = insnOk && insn.rets;
   assign retdGo = insnOk && insn.retd && sr_q[ehu_pkg::BitDbg];
   assign last = cnt_q == 4'(nWords_q - 4'h1);
   assign pushEnd = st_q == ehu_pkg::StPush && stkAck && last;
   assign popEnd = st_q == ehu_pkg::StPop && stkAck && last;
   assign popSlot = 4'(nWords_q - 4'h1 - cnt_q);

   assign busy = !insnOk;
   assign evtTaken = evtTaken_q;
   assign pcLoad = pcLoad_q;
   assign pcNew = pcNew_q;
   assign srOut = sr_q;
   assign bankSel = ehu_pkg::srMode(sr_q); // RULE12
   assign restWe = restWe_q;
   assign restIdx = restIdx_q;
   assign restData = restData_q;
   assign stkReq = !idle;
   assign stkWe = st_q == ehu_pkg::StPush;
   assign stkAddr = stkAddr_q;
   assign stkWdata = stkWdata_q;

   // ==========================================================
   // sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ehu_pkg::StIdle;
         cnt_q <= '0;
         nWords_q <= ehu_pkg::CtxWords;
         snapSr_q <= '0;
         snapPc_q <= '0;
         newSr_q <= '0;
         tgt_q <= '0;
      end else begin
         unique case (st_q)
            ehu_pkg::StIdle: begin
               cnt_q <= '0;
               if (evtGo) begin // RULE9
                  st_q <= ehu_pkg::StPush;
                  snapSr_q <= sr_q;
                  snapPc_q <= pick.pc;
                  nWords_q <= pick.isInt ? ehu_pkg::IntWords : ehu_pkg::CtxWords; // RULE10
                  newSr_q <= ehu_pkg::setMode(sr_q | (32'(pick.setm) << ehu_pkg::BitGim), pick.mode); // RULE7
                  tgt_q <= ehu_pkg::vecAddr(base_q, pick.off); // RULE1
               end else if (scallGo) begin // RULE14
                  st_q <= ehu_pkg::StPush;
                  snapSr_q <= sr_q;
                  snapPc_q <= insn.retPc;
                  nWords_q <= ehu_pkg::CtxWords;
                  newSr_q <= ehu_pkg::setMode(sr_q, ehu_pkg::MdSup);
                  tgt_q <= ehu_pkg::vecAddr(base_q, ehu_pkg::OffScall); // RULE2
               end else if (reteGo || retsGo) begin // RULE13
                  st_q <= ehu_pkg::StPop;
                  nWords_q <= (reteGo && ehu_pkg::isIntMode(sr_q)) ? ehu_pkg::IntWords : ehu_pkg::CtxWords;
               end
            end
            ehu_pkg::StPush, ehu_pkg::StPop: begin
               if (stkAck) begin
                  cnt_q <= 4'(cnt_q + 4'h1);
                  if (last) st_q <= ehu_pkg::StIdle;
               end
            end
            default: st_q <= ehu_pkg::StIdle;
         endcase
      end
   end

   // context registers are frozen at acceptance so the frame is atomic
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) regs_q <= '0;
      else if (evtGo) regs_q <= saveRegs; // RULE10
   end

   // ==========================================================
   // stack port
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stkAddr_q <= '0;
         stkWdata_q <= '0;
      end else if (evtGo || scallGo) begin
         stkAddr_q <= sp_q - ehu_pkg::WordBytes; // RULE21
         stkWdata_q <= evtGo ? pick.pc : insn.retPc;
      end else if (reteGo || retsGo) begin
         stkAddr_q <= sp_q; // RULE21
      end else if (stkAck && st_q == ehu_pkg::StPush) begin
         stkAddr_q <= stkAddr_q - ehu_pkg::WordBytes;
         stkWdata_q <= wordAt(4'(cnt_q + 4'h1));
      end else if (stkAck && st_q == ehu_pkg::StPop) begin
         stkAddr_q <= stkAddr_q + ehu_pkg::WordBytes;
      end
   end

   // the pointer moves only when a whole frame is done, or on a bus write to it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) sp_q <= ehu_pkg::SpReset;
      else if (pushEnd) sp_q <= stkAddr_q; // RULE21
      else if (popEnd) sp_q <= stkAddr_q + ehu_pkg::WordBytes; // RULE21
      else if (wrSp) sp_q <= wmerge(sp_q, wData_q, wStrb_q);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         restWe_q <= 1'b0;
         restIdx_q <= '0;
         restData_q <= '0;
         popSr_q <= '0;
      end else begin
         restWe_q <= 1'b0;
         if (st_q == ehu_pkg::StPop && stkAck) begin
            if (popSlot == ehu_pkg::SrSlot) begin
               popSr_q <= stkRdata; // RULE13
            end else if (popSlot >= ehu_pkg::RegSlot0) begin
               restWe_q <= 1'b1; // RULE13
               restIdx_q <= 3'(popSlot - ehu_pkg::RegSlot0);
               restData_q <= stkRdata;
            end
         end
      end
   end

   // ==========================================================
   // program counter, status and debug return registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pcLoad_q <= 1'b0;
         pcNew_q <= '0;
         evtTaken_q <= 1'b0;
      end else begin
         pcLoad_q <= dbgGo || retdGo || pushEnd || popEnd;
         evtTaken_q <= evtGo; // RULE8
         if (dbgGo) pcNew_q <= dbgHandler; // RULE16
         else if (retdGo) pcNew_q <= dbgAddr_q; // RULE19
         else if (pushEnd) pcNew_q <= tgt_q; // RULE12
         else if (popEnd) pcNew_q <= stkRdata; // RULE13
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dbgStat_q <= '0;
         dbgAddr_q <= '0;
      end else if (dbgGo) begin
         dbgStat_q <= sr_q; // RULE17
         dbgAddr_q <= curPc; // RULE17
      end
   end

   // hardware updates win; a bus write colliding with them is dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) sr_q <= ehu_pkg::SrReset;
      else if (dbgGo) sr_q <= ehu_pkg::setMode(sr_q, ehu_pkg::MdExc) | ehu_pkg::SrDbgFlag; // RULE16
      else if (retdGo) sr_q <= dbgStat_q; // RULE19
      else if (pushEnd) sr_q <= newSr_q; // RULE12
      else if (popEnd) sr_q <= popSr_q; // RULE23
      else if (wrSr && sr_q[ehu_pkg::BitDbg]) sr_q <= wmerge(sr_q, wData_q, wStrb_q); // RULE18
      else if (wrSr) sr_q <= ehu_pkg::setMode(wmerge(sr_q, wData_q, wStrb_q), ehu_pkg::srMode(sr_q));
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) base_q <= ehu_pkg::BaseReset;
      else if (wrBase) base_q <= wmerge(base_q, wData_q, wStrb_q);
   end

   // ==========================================================
   // bus slave
   assign awready = !awHas_q;
   assign wready = !wHas_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = !rvalid_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign wrDo = awHas_q && wHas_q && !bvalid_q;
   assign wrSr = wrDo && awAddr_q == ehu_pkg::AdrSr;
   assign wrBase = wrDo && awAddr_q == ehu_pkg::AdrBase;
   assign wrSp = wrDo && awAddr_q == ehu_pkg::AdrSp;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHas_q <= 1'b0;
         wHas_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= ehu_pkg::RespOkay;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else begin
         if (awvalid && !awHas_q) begin
            awHas_q <= 1'b1;
            awAddr_q <= awaddr[ehu_pkg::AdrW-1:0];
         end
         if (wvalid && !wHas_q) begin
            wHas_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (wrDo) begin
            awHas_q <= 1'b0;
            wHas_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (wrSr || wrBase || wrSp) ? ehu_pkg::RespOkay : ehu_pkg::RespDecErr;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= ehu_pkg::RespOkay;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= ehu_pkg::RespOkay;
         case (araddr[ehu_pkg::AdrW-1:0])
            ehu_pkg::AdrSr: rdata_q <= sr_q;
            ehu_pkg::AdrBase: rdata_q <= base_q;
            ehu_pkg::AdrDbgStat: rdata_q <= dbgStat_q;
            ehu_pkg::AdrDbgAddr: rdata_q <= dbgAddr_q;
            ehu_pkg::AdrSp: rdata_q <= sp_q;
            ehu_pkg::AdrState: rdata_q <= 32'({st_q, nWords_q, cnt_q});
            default: begin
               rdata_q <= '0;
               rresp_q <= ehu_pkg::RespDecErr;
            end
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   handler_or_a: assert property (pushEnd |=> (pcNew_q & base_q) == base_q) // RULE1
      else $error("handler address lost vector base bits");
   crit_unmasked_a: assert property (idle && !dbgGo && excOld.vld && excOld.crit |-> evtGo ##1 st_q == ehu_pkg::StPush) // RULE6
      else $error("critical exception not accepted");
   int_masked_a: assert property (evtGo && pick.isInt |-> !sr_q[ehu_pkg::BitGim]) // RULE5
      else $error("interrupt accepted under global mask");
   exc_masks_a: assert property (evtGo && pick.mode == ehu_pkg::MdExc |=> newSr_q[ehu_pkg::BitExm] && newSr_q[ehu_pkg::BitGim]) // RULE11
      else $error("exception entry left masks clear");
   int_frame_a: assert property (evtGo && pick.isInt |=> nWords_q == ehu_pkg::IntWords && st_q == ehu_pkg::StPush) // RULE10
      else $error("interrupt frame size wrong");
   sp_step_a: assert property (st_q == ehu_pkg::StPush && stkAck && !last |=> stkAddr_q == $past(stkAddr_q) - ehu_pkg::WordBytes) // RULE21
      else $error("stack address did not step down one word");
   dbg_entry_a: assert property (dbgGo |=> sr_q[ehu_pkg::BitDbg] && pcLoad_q && pcNew_q == $past(dbgHandler) && !stkReq) // RULE16
      else $error("debug entry incomplete");
   dbg_blocked_a: assert property (idle && dbgReq && sr_q[ehu_pkg::BitDbm] && !sr_q[ehu_pkg::BitDbg] |-> !dbgGo) // RULE15
      else $error("debug entered while masked");
   ret_restore_a: assert property (popEnd |=> sr_q == $past(popSr_q) && pcLoad_q && pcNew_q == $past(stkRdata)) // RULE23
      else $error("return did not restore status and pc");
endmodule // ehu_core
`default_nettype wire

// File: sim/ehu_irq_model.sv
// ehu_irq_model: interrupt controller model that arbitrates four levels
`timescale 1ns/1ns
`default_nettype none
module ehu_irq_model (
   input wire logic [3:0] pend,
   input wire logic [3:0][13:0] offTab,
   output logic [3:0] intReq,
   output logic [13:0] intOff
);
   // the bench drops a level once the core has accepted it, and drops the refused level 1 after its wait
   assign intReq = pend;
   // the highest pending level wins; with none pending the offset is junk, not stale
   always_comb begin
      intOff = 14'h2aaa;
      for (int i = 0; i < 4; i++) begin
         if (pend[i]) intOff = offTab[i];
      end
   end
endmodule // ehu_irq_model
`default_nettype wire

// File: sim/ehu_core_bench.sv
// ehu_core_bench: self-checking bench of the event handling core
`timescale 1ns/1ns
`default_nettype none
module ehu_core_bench;
   logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata, dbgHandler, curPc, pcNew, srOut, restData, stkAddr, stkWdata, stkRdata;
   logic [3:0] wstrb, intReq, pend;
   logic [1:0] bresp, rresp;
   logic [13:0] intOff;
   logic [3:0][13:0] offTab;
   logic [5:0][31:0] saveRegs;
   logic nmi, dbgReq, busy, evtTaken, pcLoad, restWe, stkReq, stkWe, stkAck;
   logic [2:0] restIdx;
   ehu_pkg::ehu_exc_t excOld, excYoung;
   ehu_pkg::ehu_insn_t insn;
   ehu_pkg::ehu_mode_t bankSel;
   logic [31:0] mem [256];
   logic [31:0] pushA[$], pushD[$], q;
   int n_fail, total_checks, nRest;

   ehu_core i_ehu_core (.clk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .excOld, .excYoung, .intReq,
      .intOff, .nmi, .dbgReq, .dbgHandler, .insn, .curPc, .saveRegs, .busy, .evtTaken, .pcLoad, .pcNew, .srOut,
      .bankSel, .restWe, .restIdx, .restData, .stkReq, .stkWe, .stkAddr, .stkWdata, .stkAck, .stkRdata);
   ehu_irq_model i_ehu_irq_model (.pend, .offTab, .intReq, .intOff);

   // ==========================================================
   // stack memory: prompt ack, junk data when not addressed
   assign stkAck = stkReq;
   assign stkRdata = stkReq ? mem[stkAddr[9:2]] : ~mem[stkAddr[9:2]];
   always @(posedge clk) begin
      if (stkReq && stkWe) begin
         mem[stkAddr[9:2]] <= stkWdata;
         pushA.push_back(stkAddr);
         pushD.push_back(stkWdata);
      end
      if (restWe) begin
         nRest++;
         chk("rest", restData, saveRegs[restIdx]);
      end
   end

   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask

   // one bus access; each channel is released just after the rising edge that takes it
   task automatic ax(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tr;
      logic [1:0] rs;
      tr = 0;
      @(posedge clk);
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      awaddr <= {20'h0, a};
      araddr <= {20'h0, a};
      wdata <= d;
      while (!tr) begin
         @(posedge clk);
         ta = w ? awvalid & awready : arvalid & arready;
         tw = wvalid & wready;
         tr = w ? bvalid & bready : rvalid & rready;
         q = rdata;
         rs = w ? bresp : rresp;
         if (ta) awvalid <= 0;
         if (ta) arvalid <= 0;
         if (tw) wvalid <= 0;
         if (tr) bready <= 0;
         if (tr) rready <= 0;
      end
      chk("resp", {30'h0, rs}, {30'h0, er});
   endtask

   // waits for the handler jump; drops every request once the core has taken it
   task automatic waitPc(input logic ok, input logic [31:0] exp);
      logic hit, e;
      logic [31:0] p;
      hit = 0;
      for (int n = 0; n < 40 && !hit; n++) begin
         @(negedge clk);
         hit = pcLoad;
         p = pcNew;
         e = evtTaken | pcLoad;
         @(posedge clk);
         if (e) begin
            pend <= 0;
            nmi <= 0;
            dbgReq <= 0;
            excOld <= '0;
            excYoung <= '0;
         end
      end
      chk("pcLoad", {31'h0, hit}, {31'h0, ok});
      if (ok) chk("pcNew", p, exp);
   endtask

   task automatic doInsn(input ehu_pkg::ehu_insn_t v);
      @(posedge clk);
      insn <= v;
      @(negedge clk);
      for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk);
      @(posedge clk);
      insn <= '0;
   endtask

   task automatic summarize;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic tRegs;
      ax(0, ehu_pkg::AdrSr, 0, ehu_pkg::RespOkay);
      chk("srRst", q, ehu_pkg::SrReset);
      ax(0, 12'h008, 0, ehu_pkg::RespDecErr);
      chk("unmapped", q, 32'h0);
      ax(1, ehu_pkg::AdrDbgStat, 32'h1, ehu_pkg::RespDecErr);
      ax(1, ehu_pkg::AdrBase, 32'h0001_0100, ehu_pkg::RespOkay);
      ax(1, ehu_pkg::AdrSp, 32'h0000_0200, ehu_pkg::RespOkay);
      ax(1, ehu_pkg::AdrSr, 32'h0040_0000, ehu_pkg::RespOkay);
   endtask

   // level 2 entry, masked level 1, nmi preempting, two returns
   task automatic tInt;
      offTab[2] <= 14'h0104;
      offTab[1] <= 14'h0008;
      pend <= 4'b0100;
      waitPc(1, 32'h0001_0104);
      chk("nPush", pushA.size(), 8);
      chk("push0A", pushA[0], 32'h1fc);
      chk("push0D", pushD[0], curPc);
      chk("push1D", pushD[1], 32'h0040_0000);
      chk("pushLink", pushD[7], saveRegs[5]);
      chk("srInt", srOut, 32'h010e_0000);
      chk("bank", {29'h0, bankSel}, {29'h0, ehu_pkg::MdLv2});
      pend <= 4'b0010;
      waitPc(0, 0);
      pend <= 0;
      nmi <= 1;
      waitPc(1, 32'h0001_0110);
      chk("srNmi", srOut, 32'h01ff_0000);
      chk("nmiSr", pushD[9], 32'h010e_0000);
      doInsn('{1'b0, 1'b1, 1'b0, 1'b0, 32'h0});
      waitPc(1, curPc);
      chk("srBack", srOut, 32'h010e_0000);
      doInsn('{1'b0, 1'b1, 1'b0, 1'b0, 32'h0});
      waitPc(1, curPc);
      chk("srApp", srOut, 32'h0040_0000);
      chk("nRest", nRest, 6);
      ax(0, ehu_pkg::AdrSp, 0, ehu_pkg::RespOkay);
      chk("spBack", q, 32'h200);
   endtask

   task automatic tExcScall;
      excOld <= '{1'b1, 1'b0, 14'h0020, 32'h0000_2000};
      excYoung <= '{1'b1, 1'b0, 14'h0024, 32'h0000_2004};
      waitPc(1, 32'h0001_0120);
      chk("srExc", srOut, 32'h01a1_0000);
      excOld <= '{1'b1, 1'b1, 14'h0004, 32'h0000_2100};
      waitPc(1, 32'h0001_0104);
      doInsn('{1'b0, 1'b1, 1'b0, 1'b0, 32'h0});
      waitPc(1, 32'h0000_2100);
      doInsn('{1'b0, 1'b1, 1'b0, 1'b0, 32'h0});
      waitPc(1, 32'h0000_2000);
      doInsn('{1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_3002});
      waitPc(1, 32'h0001_0100);
      chk("scPc", pushD[pushD.size() - 2], 32'h3002);
      doInsn('{1'b0, 1'b0, 1'b1, 1'b0, 32'h0});
      waitPc(1, 32'h3002);
      chk("srRets", srOut, 32'h0040_0000);
   endtask

   task automatic tDbg;
      int n0;
      n0 = pushA.size();
      dbgReq <= 1;
      waitPc(1, dbgHandler);
      chk("dbgFlag", {31'h0, srOut[27]}, 32'h1);
      chk("noPush", pushA.size(), n0);
      ax(0, ehu_pkg::AdrDbgAddr, 0, ehu_pkg::RespOkay);
      chk("dbgRa", q, curPc);
      ax(0, ehu_pkg::AdrDbgStat, 0, ehu_pkg::RespOkay);
      chk("dbgRs", q, 32'h0040_0000);
      ax(1, ehu_pkg::AdrSr, 32'h0940_0000, ehu_pkg::RespOkay);
      ax(0, ehu_pkg::AdrSr, 0, ehu_pkg::RespOkay);
      chk("dbgMode", {29'h0, q[24:22]}, 32'h5);
      doInsn('{1'b0, 1'b0, 1'b0, 1'b1, 32'h0});
      waitPc(1, curPc);
      chk("srRetd", srOut, 32'h0040_0000);
      ax(1, ehu_pkg::AdrSr, 32'h0440_0000, ehu_pkg::RespOkay);
      dbgReq <= 1;
      waitPc(0, 0);
      dbgReq <= 0;
   endtask

   initial begin
      rst_b = 0;
      {awvalid, wvalid, bready, arvalid, rready, nmi, dbgReq} = '0;
      {awaddr, wdata, araddr, pend, offTab, excOld, excYoung, insn} = '0;
      wstrb = 4'hf;
      dbgHandler = 32'h0000_9000;
      curPc = 32'h0000_1230;
      for (int i = 0; i < 6; i++) saveRegs[i] = 32'h00a0 + i;
      repeat (16) @(posedge clk);
      rst_b <= 1;
      tRegs();
      tInt();
      tExcScall();
      tDbg();
      summarize();
   end

   // hang guard: the run needs far fewer than 4000 cycles
   initial begin
      #160000;
      n_fail++;
      summarize();
   end
endmodule // ehu_core_bench
`default_nettype wire
